// ### inc/rocof_pkg.sv
// Constants shared by the rate-of-change-of-frequency detector
package rocof_pkg;
  // System clock
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_PERIOD_NS = 20;
  // Accepted measurement band in mHz, and the period bounds it implies in clock cycles
  localparam int FREQ_MIN_MHZ = 40_000;
  localparam int FREQ_MAX_MHZ = 70_000;
  localparam int PERIOD_MIN_CYC = (CLK_HZ / 70) + 1;
  localparam int PERIOD_MAX_CYC = CLK_HZ / 40;
  localparam int PERIOD_W = 21;
  localparam int FREQ_W = 17;
  // Numerator turning an averaged period in cycles into mHz
  localparam longint FREQ_NUM = longint'(CLK_HZ) * 1000;
  localparam int DIV_W = 36;
  // Run lengths for acceptance and for dropping the frequency
  localparam int VALID_RUN = 4;
  localparam int INVALID_RUN = 4;
  // Five signal periods hold ten zero crossings
  localparam int HIST_PERIODS = 5;
  localparam int HIST_DEPTH = 2 * HIST_PERIODS;
  // Least voltage, in percent of rated
  localparam int VOLT_LIMIT_PCT = 10;
  // Threshold in 0.01 Hz/s, signed
  localparam int THR_W = 11;
  localparam int THR_MIN = -500;
  localparam int THR_MAX = 500;
  localparam int THR_DEFAULT = 50;
  // Delta(mHz) * f(mHz) / DFDT_SCALE gives df/dt in 0.01 Hz/s over five periods
  localparam int DFDT_SCALE = 50_000;
  localparam int PROD_W = 36;
  // Timing
  localparam int MS_NS = 1_000_000;
  localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam int FILTER_MS = 100;
  localparam int DELAY_W = 14;
  localparam int DELAY_MIN_MS = 200;
  localparam int DELAY_MAX_MS = 10_000;
  localparam int DELAY_DEFAULT_MS = 200;
endpackage

// ### hw/rocof_period_meter.sv
// Zero-crossing period meter and period-to-frequency divider
`timescale 1ns/10ps
module rocof_period_meter #(
  parameter int PERIOD_MIN = rocof_pkg::PERIOD_MIN_CYC,
  parameter int PERIOD_MAX = rocof_pkg::PERIOD_MAX_CYC
) (
  input wire logic i_clk, // System clock
  input wire logic i_srst, // Synchronous reset, high
  input wire logic i_sign, // Voltage sign from the pin, asynchronous
  output logic o_stb, // One-cycle pulse per measurement
  output logic o_valid, // Measurement inside the band
  output logic [rocof_pkg::FREQ_W-1:0] o_freq // Frequency in mHz
);
  localparam int PW = rocof_pkg::PERIOD_W;
  localparam int DW = rocof_pkg::DIV_W;
  localparam logic [PW-1:0] PMIN = PW'(PERIOD_MIN);
  localparam logic [PW-1:0] PMAX = PW'(PERIOD_MAX);
  localparam logic [DW-1:0] NUM = DW'(rocof_pkg::FREQ_NUM);

  logic s1, s2, s3, level, seen_rise, seen_fall, rise_ok, fall_ok, busy;
  logic [PW-1:0] rise_cnt, fall_cnt, rise_per, fall_per, divisor;
  logic [DW:0] rem;
  logic [DW-1:0] quo;
  logic [5:0] bit_idx;

  // Three-stage synchroniser; a change counts once the last two stages agree
  wire settled = (s2 == s3);
  wire rise = settled && s3 && !level;
  wire fall = settled && !s3 && level;
  wire timeout = (rise_cnt >= PMAX) || (fall_cnt >= PMAX);
  wire [PW-1:0] new_rise = rise ? rise_cnt : rise_per;
  wire [PW-1:0] new_fall = fall ? fall_cnt : fall_per;
  // A period exists only from the second edge of a kind; the first edge after reset
  // or a timeout holds a count from an arbitrary start and never makes a measurement
  wire both_seen = (rise_ok || (rise && seen_rise)) && (fall_ok || (fall && seen_fall));
  wire in_band = (new_rise >= PMIN) && (new_rise <= PMAX) && (new_fall >= PMIN)
    && (new_fall <= PMAX);
  wire [PW:0] per_sum = {1'b0, new_rise} + {1'b0, new_fall};
  // Frequency rests on the mean of the rise-to-rise and fall-to-fall periods
  wire [PW-1:0] per_avg = per_sum[PW:1];
  wire crossing = rise || fall;
  wire start_div = crossing && both_seen && in_band;
  wire [DW:0] rem_shift = {rem[DW-1:0], NUM[bit_idx]};
  wire rem_ge = rem_shift >= {{(DW+1-PW){1'b0}}, divisor};

  // Synchroniser and settled level
  always_ff @(posedge i_clk)
  begin
    s1 <= i_sign;
    s2 <= s1;
    s3 <= s2;
    if (i_srst)
      level <= 1'b0;
    else if (settled)
      level <= s3;
  end

  // Separate period counters for rising and falling crossings
  always_ff @(posedge i_clk)
  begin
    if (i_srst || timeout)
    begin
      rise_cnt <= '0;
      fall_cnt <= '0;
      seen_rise <= 1'b0;
      seen_fall <= 1'b0;
      rise_ok <= 1'b0;
      fall_ok <= 1'b0;
    end
    else
    begin
      rise_cnt <= rise ? PW'(1) : rise_cnt + PW'(1);
      fall_cnt <= fall ? PW'(1) : fall_cnt + PW'(1);
      seen_rise <= seen_rise || rise;
      seen_fall <= seen_fall || fall;
      rise_ok <= rise_ok || (rise && seen_rise);
      fall_ok <= fall_ok || (fall && seen_fall);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      rise_per <= '0;
      fall_per <= '0;
    end
    else
    begin
      rise_per <= new_rise;
      fall_per <= new_fall;
    end
  end

  // Restoring divider, one quotient bit per clock; crossings are far slower than this
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      busy <= 1'b0;
      rem <= '0;
      quo <= '0;
      bit_idx <= '0;
      divisor <= PMAX;
    end
    else if (start_div)
    begin
      busy <= 1'b1; // An in-band crossing mid-division restarts it with fresher data
      rem <= '0;
      quo <= '0;
      bit_idx <= 6'(DW - 1);
      divisor <= per_avg;
    end
    else if (busy)
    begin
      rem <= rem_ge ? rem_shift - {{(DW+1-PW){1'b0}}, divisor} : rem_shift;
      quo <= {quo[DW-2:0], rem_ge};
      bit_idx <= bit_idx - 6'd1;
      busy <= (bit_idx != 6'd0);
    end
  end

  // Result strobe: a finished division, or an invalid crossing or a lost signal
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_stb <= 1'b0;
      o_valid <= 1'b0;
      o_freq <= '0;
    end
    else
    begin
      o_stb <= (busy && bit_idx == 6'd0 && !start_div) || (crossing && !start_div) || timeout;
      o_valid <= busy && bit_idx == 6'd0 && !start_div;
      if (busy && bit_idx == 6'd0 && !start_div)
        o_freq <= {quo[rocof_pkg::FREQ_W-2:0], rem_ge};
    end
  end
endmodule // rocof_period_meter

// ### hw/rocof_protection_detector.sv
// Rate-of-change-of-frequency protection detector, top level
`timescale 1ns/10ps
module rocof_protection_detector #(
  parameter int CYCLES_PER_MS = rocof_pkg::CYCLES_PER_MS,
  parameter int PERIOD_MIN = rocof_pkg::PERIOD_MIN_CYC,
  parameter int PERIOD_MAX = rocof_pkg::PERIOD_MAX_CYC
) (
  input wire logic I_SYS_CLK, // System clock, 50 MHz
  input wire logic I_SRST, // Synchronous reset, high
  input wire logic I_VOLT_SIGN, // Sign of the monitored voltage, asynchronous
  input wire logic [15:0] I_VOLT_RMS, // Present voltage magnitude
  input wire logic [15:0] I_VOLT_RATED, // Rated voltage, same scale
  input wire logic I_OPERATION_ON, // Function enable
  input wire logic I_START_ONLY, // Start signal only
  input wire logic signed [rocof_pkg::THR_W-1:0] I_ROCOF_THRESHOLD, // 0.01 Hz/s
  input wire logic [rocof_pkg::DELAY_W-1:0] I_TIME_DELAY_MS, // Trip delay in ms
  input wire logic I_ROCOF_BLOCK_IN, // Blocking input
  output logic O_ROCOF_GENERAL_START, // General start
  output logic O_ROCOF_GENERAL_TRIP, // General trip
  output logic O_START_EVENT, // Pulse on each start change
  output logic O_TRIP_EVENT, // Pulse on each trip change
  output logic [rocof_pkg::FREQ_W-1:0] O_FREQ_MHZ, // Held frequency in mHz
  output logic O_FREQ_ACCEPTED // Frequency accepted
);
  localparam int FW = rocof_pkg::FREQ_W;
  localparam int PRW = rocof_pkg::PROD_W;
  localparam int DLW = rocof_pkg::DELAY_W;
  localparam int TW = rocof_pkg::THR_W;
  localparam int HD = rocof_pkg::HIST_DEPTH;
  localparam logic [2:0] VALID_RUN = 3'(rocof_pkg::VALID_RUN);
  localparam logic [2:0] INVALID_RUN = 3'(rocof_pkg::INVALID_RUN);
  localparam logic [3:0] HIST_FULL = 4'(HD);
  localparam logic signed [TW-1:0] THR_LO = TW'(rocof_pkg::THR_MIN);
  localparam logic signed [TW-1:0] THR_HI = TW'(rocof_pkg::THR_MAX);
  localparam logic signed [PRW-1:0] SCALE = PRW'(rocof_pkg::DFDT_SCALE);
  localparam logic [DLW-1:0] DLY_LO = DLW'(rocof_pkg::DELAY_MIN_MS);
  localparam logic [DLW-1:0] DLY_HI = DLW'(rocof_pkg::DELAY_MAX_MS);
  localparam logic [DLW-1:0] FILTER = DLW'(rocof_pkg::FILTER_MS);
  localparam logic [31:0] MS_LAST = 32'(CYCLES_PER_MS - 1);
  localparam logic [31:0] PCT = 32'(rocof_pkg::VOLT_LIMIT_PCT);

  logic m_stb, m_valid;
  logic [FW-1:0] m_freq;
  logic [2:0] valid_run, invalid_run;
  logic accepted;
  logic [FW-1:0] freq_held;
  logic [FW-1:0] hist [HD];
  logic [3:0] hist_fill;
  logic exceed;
  logic [31:0] ms_div;
  logic [DLW-1:0] fault_ms;

  // Zero-crossing period measurement and conversion to mHz
  rocof_period_meter #(
    .PERIOD_MIN(PERIOD_MIN),
    .PERIOD_MAX(PERIOD_MAX)
  ) u_meter (
    .i_clk(I_SYS_CLK),
    .i_srst(I_SRST),
    .i_sign(I_VOLT_SIGN),
    .o_stb(m_stb),
    .o_valid(m_valid),
    .o_freq(m_freq)
  );

  // Run bookkeeping for acceptance and drop-out
  wire [2:0] valid_inc = (valid_run == VALID_RUN) ? valid_run : valid_run + 3'd1;
  wire [2:0] invalid_inc = (invalid_run == INVALID_RUN) ? invalid_run : invalid_run + 3'd1;
  wire now_accepted = (valid_inc == VALID_RUN);
  wire now_dropped = (invalid_inc == INVALID_RUN);

  // Settings clamped to their legal ranges, so an out-of-range value cannot misbehave
  wire signed [TW-1:0] thr = (I_ROCOF_THRESHOLD < THR_LO) ? THR_LO :
    (I_ROCOF_THRESHOLD > THR_HI) ? THR_HI : I_ROCOF_THRESHOLD;
  wire [DLW-1:0] delay_ms = (I_TIME_DELAY_MS < DLY_LO) ? DLY_LO :
    (I_TIME_DELAY_MS > DLY_HI) ? DLY_HI : I_TIME_DELAY_MS;

  // Voltage above ten percent of rated: rms*100 > rated*pct, no divide needed
  wire [31:0] volt_scaled = {16'h0000, I_VOLT_RMS} * 32'h0000_0064;
  wire [31:0] rated_scaled = {16'h0000, I_VOLT_RATED} * PCT;
  wire volt_ok = volt_scaled > rated_scaled;

  // Change over five periods, scaled by frequency to give Hz/s; compared against
  // threshold*scale so the datapath never divides
  wire signed [FW:0] delta = $signed({1'b0, m_freq}) - $signed({1'b0, hist[HD-1]});
  wire signed [PRW-1:0] prod = PRW'(delta) * $signed(PRW'({1'b0, m_freq}));
  wire signed [PRW-1:0] thr_scaled = PRW'(thr) * SCALE;
  // A negative setting operates on a falling frequency below it
  wire over = (thr >= 0) ? (prod > thr_scaled) : (prod < thr_scaled);
  wire eval_ok = m_valid && accepted && (hist_fill == HIST_FULL);

  // Fault condition: enabled, unblocked, frequency good, voltage high, slope beyond setting
  wire raw_fault = I_OPERATION_ON && !I_ROCOF_BLOCK_IN && accepted && volt_ok
    && exceed;
  wire ms_tick = raw_fault && (ms_div == MS_LAST);
  wire next_start = raw_fault && (fault_ms >= FILTER);
  // Same timer serves filter and trip delay, so the delay runs from fault onset
  wire next_trip = next_start && !I_START_ONLY && (fault_ms >= delay_ms);

  // Valid and invalid run counters
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_SRST)
    begin
      valid_run <= '0;
      invalid_run <= '0;
    end
    else if (m_stb)
    begin
      valid_run <= m_valid ? valid_inc : 3'd0;
      invalid_run <= m_valid ? 3'd0 : invalid_inc;
    end
  end

  // Held frequency and its acceptance flag
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_SRST)
    begin
      accepted <= 1'b0;
      freq_held <= '0;
    end
    else if (m_stb && m_valid)
    begin
      freq_held <= m_freq;
      accepted <= accepted || now_accepted;
    end
    else if (m_stb && now_dropped)
    begin
      freq_held <= '0;
      accepted <= 1'b0;
    end
  end

  // Frequency history, one entry per crossing; an invalid crossing empties it
  generate
    for (genvar i = 0; i < HD; i++)
    begin : g_hist
      always_ff @(posedge I_SYS_CLK)
      begin
        if (I_SRST)
          hist[i] <= '0;
        else if (m_stb && m_valid)
          hist[i] <= (i == 0) ? m_freq : hist[(i == 0) ? 0 : i - 1];
      end
    end
  endgenerate

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_SRST)
      hist_fill <= '0;
    else if (m_stb)
      hist_fill <= !m_valid ? 4'd0 : (hist_fill == HIST_FULL) ? hist_fill : hist_fill + 4'd1;
  end

  // Comparator result, refreshed at each crossing and cleared when frequency is lost
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_SRST || !accepted)
      exceed <= 1'b0;
    else if (m_stb)
      exceed <= eval_ok && over;
  end

  // Millisecond prescaler and fault timer, both restart whenever the fault goes away
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_SRST || !raw_fault)
    begin
      ms_div <= '0;
      fault_ms <= '0;
    end
    else
    begin
      ms_div <= ms_tick ? 32'h0000_0000 : ms_div + 32'h0000_0001;
      if (ms_tick && fault_ms != DLY_HI)
        fault_ms <= fault_ms + 14'h0001;
    end
  end

  // Registered outputs and change events
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_SRST)
    begin
      O_ROCOF_GENERAL_START <= 1'b0;
      O_ROCOF_GENERAL_TRIP <= 1'b0;
      O_START_EVENT <= 1'b0;
      O_TRIP_EVENT <= 1'b0;
      O_FREQ_MHZ <= '0;
      O_FREQ_ACCEPTED <= 1'b0;
    end
    else
    begin
      O_ROCOF_GENERAL_START <= next_start;
      O_ROCOF_GENERAL_TRIP <= next_trip;
      O_START_EVENT <= next_start != O_ROCOF_GENERAL_START;
      O_TRIP_EVENT <= next_trip != O_ROCOF_GENERAL_TRIP;
      O_FREQ_MHZ <= freq_held;
      O_FREQ_ACCEPTED <= accepted;
    end
  end
endmodule // rocof_protection_detector

// ### dv/rocof_protection_detector_assertions.sv
// Port-level checks for the rate-of-change-of-frequency detector
`timescale 1ns/10ps
module rocof_protection_detector_assertions #(
  parameter int CYCLES_PER_MS = rocof_pkg::CYCLES_PER_MS
) (
  input wire logic I_SYS_CLK, // Clock
  input wire logic I_SRST, // Reset
  input wire logic I_VOLT_SIGN, // Sign
  input wire logic [15:0] I_VOLT_RMS, // Voltage
  input wire logic [15:0] I_VOLT_RATED, // Rated
  input wire logic I_OPERATION_ON, // Enable
  input wire logic I_START_ONLY, // No trip
  input wire logic signed [rocof_pkg::THR_W-1:0] I_ROCOF_THRESHOLD, // Threshold
  input wire logic [rocof_pkg::DELAY_W-1:0] I_TIME_DELAY_MS, // Delay
  input wire logic I_ROCOF_BLOCK_IN, // Block
  input wire logic O_ROCOF_GENERAL_START, // Start
  input wire logic O_ROCOF_GENERAL_TRIP, // Trip
  input wire logic O_START_EVENT, // Start event
  input wire logic O_TRIP_EVENT, // Trip event
  input wire logic [rocof_pkg::FREQ_W-1:0] O_FREQ_MHZ, // Frequency
  input wire logic O_FREQ_ACCEPTED // Accepted
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SRST);
  // Enabling conditions; frequency and exceedance are hidden, so this is a lower bound only
  logic [31:0] ok_run;
  wire volt_ok = (32'(I_VOLT_RMS) * 32'h64) > (32'(I_VOLT_RATED) * 32'hA);
  wire cond_ok = I_OPERATION_ON && !I_ROCOF_BLOCK_IN && volt_ok;
  wire [13:0] dly = (I_TIME_DELAY_MS < 14'h0C8) ? 14'h0C8 :
    (I_TIME_DELAY_MS > 14'h2710) ? 14'h2710 : I_TIME_DELAY_MS;
  wire [31:0] trip_min = (32'(dly) - 32'h1) * CYCLES_PER_MS;
  // Saturating run counter, so a long healthy stretch never wraps back to zero
  always_ff @(posedge I_SYS_CLK)
    if (I_SRST || !cond_ok)
      ok_run <= '0;
    else if (ok_run != '1)
      ok_run <= ok_run + 32'h1;
  property p_trip_with_start; O_ROCOF_GENERAL_TRIP |-> O_ROCOF_GENERAL_START; endproperty
  a_trip_with_start: assert property (p_trip_with_start) else $error("trip without start");
  property p_start_only; I_START_ONLY |=> !O_ROCOF_GENERAL_TRIP; endproperty
  a_start_only: assert property (p_start_only) else $error("trip in start-only mode");
  property p_oper_off;
    !I_OPERATION_ON |=> !O_ROCOF_GENERAL_START && !O_ROCOF_GENERAL_TRIP;
  endproperty
  a_oper_off: assert property (p_oper_off) else $error("output while off");
  property p_block;
    I_ROCOF_BLOCK_IN |=> !O_ROCOF_GENERAL_START && !O_ROCOF_GENERAL_TRIP;
  endproperty
  a_block: assert property (p_block) else $error("output while blocked");
  property p_volt; !volt_ok |=> !O_ROCOF_GENERAL_START; endproperty
  a_volt: assert property (p_volt) else $error("start at low voltage");
  property p_filter; $rose(O_ROCOF_GENERAL_START) |-> ok_run >= 99 * CYCLES_PER_MS; endproperty
  a_filter: assert property (p_filter) else $error("start before filter time");
  property p_delay; $rose(O_ROCOF_GENERAL_TRIP) |-> ok_run >= trip_min; endproperty
  a_delay: assert property (p_delay) else $error("trip before delay");
  property p_start_evt; O_START_EVENT == $changed(O_ROCOF_GENERAL_START); endproperty
  a_start_evt: assert property (p_start_evt) else $error("start event mismatch");
  property p_trip_evt; O_TRIP_EVENT == $changed(O_ROCOF_GENERAL_TRIP); endproperty
  a_trip_evt: assert property (p_trip_evt) else $error("trip event mismatch");
  property p_drop; $fell(O_FREQ_ACCEPTED) |-> ##[0:2] O_FREQ_MHZ == '0; endproperty
  a_drop: assert property (p_drop) else $error("frequency not cleared");
endmodule // rocof_protection_detector_assertions

bind rocof_protection_detector rocof_protection_detector_assertions #(
  .CYCLES_PER_MS(CYCLES_PER_MS)
) u_chk (
  .I_SYS_CLK(I_SYS_CLK), .I_SRST(I_SRST), .I_VOLT_SIGN(I_VOLT_SIGN),
  .I_VOLT_RMS(I_VOLT_RMS), .I_VOLT_RATED(I_VOLT_RATED), .I_OPERATION_ON(I_OPERATION_ON),
  .I_START_ONLY(I_START_ONLY), .I_ROCOF_THRESHOLD(I_ROCOF_THRESHOLD),
  .I_TIME_DELAY_MS(I_TIME_DELAY_MS), .I_ROCOF_BLOCK_IN(I_ROCOF_BLOCK_IN),
  .O_ROCOF_GENERAL_START(O_ROCOF_GENERAL_START), .O_ROCOF_GENERAL_TRIP(O_ROCOF_GENERAL_TRIP),
  .O_START_EVENT(O_START_EVENT), .O_TRIP_EVENT(O_TRIP_EVENT), .O_FREQ_MHZ(O_FREQ_MHZ),
  .O_FREQ_ACCEPTED(O_FREQ_ACCEPTED)
);

// ### dv/rocof_protection_detector_test.sv
// Self-checking bench for the rate-of-change-of-frequency detector
`timescale 1ns/10ps
module rocof_protection_detector_test;
  localparam int HALF = 45; // Period 90 cycles in the 40..100 band; halves outlast the divide
  logic clk, srst, sign, op, sonly, blk, start, trip, sevt, tevt, acc;
  logic [15:0] rms, rated;
  logic signed [rocof_pkg::THR_W-1:0] thr;
  logic [rocof_pkg::DELAY_W-1:0] dly;
  logic [rocof_pkg::FREQ_W-1:0] freq;
  logic [2:0] expq[$];
  logic [2:0] prev;
  int bad_count, check_count, i;
  int seed = 32'h23d83063;
  // Short periods and one cycle per ms keep the run brief; the frequency word is then
  // the low 17 bits of the quotient, not mHz
  rocof_protection_detector #(.CYCLES_PER_MS(1), .PERIOD_MIN(40), .PERIOD_MAX(100)) u_dut (
    .I_SYS_CLK(clk), .I_SRST(srst), .I_VOLT_SIGN(sign), .I_VOLT_RMS(rms),
    .I_VOLT_RATED(rated), .I_OPERATION_ON(op), .I_START_ONLY(sonly),
    .I_ROCOF_THRESHOLD(thr), .I_TIME_DELAY_MS(dly), .I_ROCOF_BLOCK_IN(blk),
    .O_ROCOF_GENERAL_START(start), .O_ROCOF_GENERAL_TRIP(trip), .O_START_EVENT(sevt),
    .O_TRIP_EVENT(tevt), .O_FREQ_MHZ(freq), .O_FREQ_ACCEPTED(acc)
  );
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic check(input string name, input logic [16:0] seen, input logic [16:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Toggles the voltage sign, one crossing per half period
  task automatic wave(input int n, input int half);
    repeat (n)
    begin
      repeat (half) @(posedge clk);
      #1 sign = ~sign;
    end
  endtask
  task automatic wrap_up;
    $display("Checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Any change of the status trio takes the oldest note; a change with no note is spurious
  always @(posedge clk)
  begin
    if (!srst && {acc, start, trip} !== prev)
    begin
      if (expq.size() == 0)
        check("unexpected status", 17'({acc, start, trip}), 17'(prev));
      else
        check("status", 17'({acc, start, trip}), 17'(expq.pop_front()));
    end
    prev = {acc, start, trip};
  end
  // Watchdog, about four times the expected run of some 12000 cycles
  initial
  begin
    #1000000;
    bad_count++;
    wrap_up();
  end
  initial
  begin
    srst = 1'b1;
    sign = 1'b0;
    op = 1'b1;
    sonly = 1'b0;
    blk = 1'b0;
    rms = 16'h03E8;
    rated = 16'h03E8;
    thr = 11'sh032;
    dly = 14'h0C8;
    prev = 3'h0;
    bad_count = 0;
    check_count = 0;
    repeat (8) @(posedge clk);
    #1 srst = 1'b0;
    @(posedge clk);
    #1 check("reset flags", 17'({acc, start, trip, sevt, tevt}), 17'h0);
    check("reset freq", freq, 17'h0);
    $display("test reset done");
    // Five crossings give at most two valid periods, too few to accept
    wave(5, HALF);
    check("early accept", 17'(acc), 17'h0);
    expq.push_back(3'b100);
    wave(10, HALF);
    $display("test acceptance done");
    // Steady frequency means zero df/dt: no setting may lead to operation
    for (i = 0; i < 8; i++)
    begin
      // Settings change with the sign toggle, so the period stays exactly 90 cycles
      op = 1'($random(seed));
      sonly = 1'($random(seed));
      blk = (i % 4) == 3;
      thr = 11'($random(seed) % 501);
      dly = 14'(200 + ({$random(seed)} % 9801));
      rms = 16'($random(seed));
      wave(22, HALF);
      check("steady start", 17'(start), 17'h0);
      check("steady trip", 17'(trip), 17'h0);
    end
    $display("test steady settings done");
    // Step to 88-cycle periods: that word is above the 90-cycle word, so ten crossings
    // see a rise beyond 0.50, long enough for start at 100 and trip at 200
    op = 1'b1;
    sonly = 1'b0;
    blk = 1'b0;
    rms = 16'h03E8;
    thr = 11'sh032;
    dly = 14'h0C8;
    expq.push_back(3'b110);
    expq.push_back(3'b111);
    expq.push_back(3'b100);
    wave(24, 44);
    check("step notes", 17'(expq.size()), 17'h0);
    $display("test rising step done");
    // Back to 90 cycles with a negative setting and start only: start, never trip
    sonly = 1'b1;
    thr = -11'sh032;
    expq.push_back(3'b110);
    expq.push_back(3'b100);
    wave(24, HALF);
    check("start only notes", 17'(expq.size()), 17'h0);
    check("start only trip", 17'(trip), 17'h0);
    $display("test start only done");
    // Sign stops: timeouts count as invalid and the held frequency drops
    expq.push_back(3'b000);
    repeat (600) @(posedge clk);
    check("dropped freq", freq, 17'h0);
    $display("test drop done");
    // Periods shorter than the band never become valid
    wave(16, 15);
    repeat (60) @(posedge clk);
    check("out of band", 17'(acc), 17'h0);
    check("pending notes", 17'(expq.size()), 17'h0);
    $display("test out of band done");
    wrap_up();
  end
endmodule // rocof_protection_detector_test
